// ---- gp_defines.svh ----
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// register addresses on the internal bus
`define GP_ADDR_OUT_A      16'hff02
`define GP_ADDR_OUT_B      16'hff03
`define GP_ADDR_OUT_C      16'hff04
`define GP_ADDR_DIR_A      16'hff22
`define GP_ADDR_DIR_B      16'hff23
`define GP_ADDR_DIR_C      16'hff24
`define GP_ADDR_PU_A       16'hff32
`define GP_ADDR_PU_B       16'hff33
`define GP_ADDR_PU_C       16'hff34
`define GP_ADDR_ANALOG     16'hff84

// reset values
`define GP_RST_DIR         8'hff
`define GP_RST_OUT         8'h00
`define GP_RST_PU          8'h00
`define GP_RST_ANALOG      8'h00

// implemented bits; unimplemented ones read as zero, but as one in the group a and b direction registers
// and as the reset pin level at bit 4 of the group b port register in port mode; the group c direction register keeps all eight bits
`define GP_MASK_A          8'h0f
`define GP_MASK_B          8'h04
`define GP_MASK_C          8'h09
`define GP_MASK_DIR_B      8'h04

// bit positions of the pins
`define GP_BIT_B_IO        2
`define GP_BIT_B_RST       4
`define GP_BIT_C_LO        0
`define GP_BIT_C_HI        3
`define GP_BIT_OSC_OUT     2
`define GP_BIT_OSC_IN      3

// option byte fields
`define GP_OPT_OSC_LSB     0
`define GP_OPT_OSC_MSB     1
`define GP_OPT_RST_FN      2

`endif

// ---- gp_pkg.sv ----
package gp_pkg;

    // system clock source chosen by the option byte
    typedef enum logic [1:0] {
        GP_OSC_INT  = 2'b00,
        GP_OSC_XTAL = 2'b01,
        GP_OSC_EXT  = 2'b10,
        GP_OSC_RSVD = 2'b11
    } gp_osc_e;

    // option capture sequence, gray along the path
    typedef enum logic [1:0] {
        GP_ST_WAIT = 2'b00,
        GP_ST_LOAD = 2'b01,
        GP_ST_RUN  = 2'b11
    } gp_state_e;

    // one internal bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic        bit_wr;
        logic [2:0]  bit_idx;
        logic        bit_val;
    } gp_bus_s;

endpackage

// ---- gp_pin_cell.sv ----
`timescale 1ns/1ps

module gp_pin_cell
    import gp_pkg::*;
(
    // configuration
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pu_sel,
    input  wire logic usable,
    input  wire logic analog,
    // pad
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe_n,
    output logic      pu_en,
    // read-back
    output logic      rd_bit
);
    logic digital;

    // a pin taken by the oscillator or the converter loses all port logic
    assign digital  = usable & ~analog;
    assign pad_out  = latch;
    assign pad_oe_n = ~(digital & ~dir);
    assign pu_en    = digital & dir & pu_sel;
    assign rd_bit   = digital & (dir ? pad_in : latch);

endmodule

// ---- gp_opt_ctl.sv ----
`timescale 1ns/1ps
`include "gp_defines.svh"

module gp_opt_ctl
    import gp_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // option byte and shared pin
    input  wire logic [7:0] option_byte,
    input  wire logic       rst_pin,
    // decoded options
    output gp_osc_e         osc_sel,
    output logic            rst_pin_is_reset,
    output logic            loaded,
    output logic            ext_reset_req
);
    gp_state_e state;
    gp_state_e next_state;
    gp_osc_e   next_osc_sel;
    logic      next_rst_fn;

    // option byte is only referenced after the pin has gone high
    always_comb begin
        next_state   = state;
        next_osc_sel = osc_sel;
        next_rst_fn  = rst_pin_is_reset;
        case (state)
            GP_ST_WAIT: begin
                if (rst_pin) begin
                    next_state = GP_ST_LOAD;
                end
            end
            GP_ST_LOAD: begin
                next_osc_sel = gp_osc_e'(option_byte[`GP_OPT_OSC_MSB:`GP_OPT_OSC_LSB]);
                next_rst_fn  = option_byte[`GP_OPT_RST_FN];
                next_state   = GP_ST_RUN;
            end
            GP_ST_RUN: begin
                next_state = GP_ST_RUN;
            end
            default: begin
                next_state = GP_ST_WAIT;
            end
        endcase
    end

    // defaults keep the pin a reset input until the byte is read
    always_ff @(posedge clk) begin
        if (rst) begin
            state            <= GP_ST_WAIT;
            osc_sel          <= GP_OSC_INT;
            rst_pin_is_reset <= 1'b1;
        end else begin
            state            <= next_state;
            osc_sel          <= next_osc_sel;
            rst_pin_is_reset <= next_rst_fn;
        end
    end

    assign loaded = (state == GP_ST_RUN);
    // low pin holds reset before the read; afterwards only in reset mode
    assign ext_reset_req = ~rst_pin & (~loaded | rst_pin_is_reset);

endmodule

// ---- gp_ports.sv ----
`timescale 1ns/1ps
`include "gp_defines.svh"

module gp_ports
    import gp_pkg::*;
#(
    parameter int DATA_W = 8
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // internal bus
    input  wire gp_bus_s           bus,
    output logic [DATA_W-1:0]      rdata,
    // option byte
    input  wire logic [7:0]        option_byte,
    output logic                   option_loaded,
    output logic                   ext_reset_req,
    output logic                   osc_in_is_clock,
    output logic                   osc_out_is_clock,
    // group a pads
    input  wire logic [3:0]        pa_in,
    output logic      [3:0]        pa_out,
    output logic      [3:0]        pa_oe_n,
    output logic      [3:0]        pa_pu_en,
    output logic      [3:0]        pa_analog_en,
    // group b pads
    input  wire logic              irq_shared_pin_b_in,
    output logic                   irq_shared_pin_b_out,
    output logic                   irq_shared_pin_b_oe_n,
    output logic                   irq_shared_pin_b_pu_en,
    input  wire logic              reset_shared_input,
    // group c pads, bit 0 and bit 3
    input  wire logic [1:0]        pc_in,
    output logic      [1:0]        pc_out,
    output logic      [1:0]        pc_oe_n,
    output logic      [1:0]        pc_pu_en,
    // interrupt input levels
    output logic                   irq_level_a,
    output logic                   irq_level_b
);
    // the register map is byte wide only
    if (DATA_W != 8) begin : g_check
        $error("gp_ports: DATA_W must be 8");
    end

    logic [7:0] dir_select_group_a, dir_select_group_b, dir_select_group_c;
    logic [7:0] out_latch_group_a, out_latch_group_b, out_latch_group_c;
    logic [7:0] pullup_select_group_a, pullup_select_group_b, pullup_select_group_c;
    logic [7:0] analog_mode_select;
    logic [7:0] next_dir_a, next_dir_b, next_dir_c;
    logic [7:0] next_out_a, next_out_b, next_out_c;
    logic [7:0] next_pu_a, next_pu_b, next_pu_c;
    logic [7:0] next_analog;
    logic [7:0] next_rdata;
    gp_osc_e    osc_sel;
    logic       rst_pin_is_reset;
    logic [6:0] c_dir, c_latch, c_pu, c_usable, c_analog, c_in;
    logic [6:0] c_out, c_oe_n, c_pu_en, c_rd;

    // byte write or single-bit write, limited to implemented bits
    function automatic logic [7:0] reg_next(input logic [7:0] old,
                                            input logic [15:0] addr,
                                            input logic [7:0] mask,
                                            input gp_bus_s b);
        logic [7:0] v;
        v = old;
        if (b.addr == addr && b.wr) begin
            v = (old & ~mask) | (b.wdata & mask);
        end else if (b.addr == addr && b.bit_wr && mask[b.bit_idx]) begin
            v[b.bit_idx] = b.bit_val;
        end
        return v;
    endfunction

    gp_opt_ctl u_opt (
        .clk              (clk),
        .rst              (rst),
        .option_byte      (option_byte),
        .rst_pin          (reset_shared_input),
        .osc_sel          (osc_sel),
        .rst_pin_is_reset (rst_pin_is_reset),
        .loaded           (option_loaded),
        .ext_reset_req    (ext_reset_req)
    );

    // oscillator pin ownership by clock source
    assign osc_in_is_clock  = (osc_sel == GP_OSC_XTAL) | (osc_sel == GP_OSC_EXT);
    assign osc_out_is_clock = (osc_sel == GP_OSC_XTAL);

    // register next values
    always_comb begin
        next_dir_a  = reg_next(dir_select_group_a, `GP_ADDR_DIR_A, `GP_MASK_A, bus);
        next_dir_b  = reg_next(dir_select_group_b, `GP_ADDR_DIR_B, `GP_MASK_DIR_B, bus);
        next_dir_c  = reg_next(dir_select_group_c, `GP_ADDR_DIR_C, 8'hff, bus);
        next_out_a  = reg_next(out_latch_group_a, `GP_ADDR_OUT_A, `GP_MASK_A, bus);
        next_out_b  = reg_next(out_latch_group_b, `GP_ADDR_OUT_B, `GP_MASK_B, bus);
        next_out_c  = reg_next(out_latch_group_c, `GP_ADDR_OUT_C, `GP_MASK_C, bus);
        next_pu_a   = reg_next(pullup_select_group_a, `GP_ADDR_PU_A, `GP_MASK_A, bus);
        next_pu_b   = reg_next(pullup_select_group_b, `GP_ADDR_PU_B, `GP_MASK_B, bus);
        next_pu_c   = reg_next(pullup_select_group_c, `GP_ADDR_PU_C, `GP_MASK_C, bus);
        next_analog = reg_next(analog_mode_select, `GP_ADDR_ANALOG, `GP_MASK_A, bus);
    end

    // register storage
    always_ff @(posedge clk) begin
        if (rst) begin
            dir_select_group_a    <= `GP_RST_DIR;
            dir_select_group_b    <= `GP_RST_DIR;
            dir_select_group_c    <= `GP_RST_DIR;
            out_latch_group_a     <= `GP_RST_OUT;
            out_latch_group_b     <= `GP_RST_OUT;
            out_latch_group_c     <= `GP_RST_OUT;
            pullup_select_group_a <= `GP_RST_PU;
            pullup_select_group_b <= `GP_RST_PU;
            pullup_select_group_c <= `GP_RST_PU;
            analog_mode_select    <= `GP_RST_ANALOG;
        end else begin
            dir_select_group_a    <= next_dir_a;
            dir_select_group_b    <= next_dir_b;
            dir_select_group_c    <= next_dir_c;
            out_latch_group_a     <= next_out_a;
            out_latch_group_b     <= next_out_b;
            out_latch_group_c     <= next_out_c;
            pullup_select_group_a <= next_pu_a;
            pullup_select_group_b <= next_pu_b;
            pullup_select_group_c <= next_pu_c;
            analog_mode_select    <= next_analog;
        end
    end

    // gather the seven io pins: a0..a3, b io, c0, c3
    always_comb begin
        c_dir    = {dir_select_group_c[`GP_BIT_C_HI], dir_select_group_c[`GP_BIT_C_LO],
                    dir_select_group_b[`GP_BIT_B_IO], dir_select_group_a[3:0]};
        c_latch  = {out_latch_group_c[`GP_BIT_C_HI], out_latch_group_c[`GP_BIT_C_LO],
                    out_latch_group_b[`GP_BIT_B_IO], out_latch_group_a[3:0]};
        c_pu     = {pullup_select_group_c[`GP_BIT_C_HI], pullup_select_group_c[`GP_BIT_C_LO],
                    pullup_select_group_b[`GP_BIT_B_IO], pullup_select_group_a[3:0]};
        c_usable = 7'h7f;
        c_usable[`GP_BIT_OSC_OUT] = ~osc_out_is_clock;
        c_usable[`GP_BIT_OSC_IN]  = ~osc_in_is_clock;
        c_analog = {3'h0, analog_mode_select[3:0]};
        c_in     = {pc_in, irq_shared_pin_b_in, pa_in};
    end

    for (genvar i = 0; i < 7; i++) begin : g_pin
        gp_pin_cell u_cell (
            .dir      (c_dir[i]),
            .latch    (c_latch[i]),
            .pu_sel   (c_pu[i]),
            .usable   (c_usable[i]),
            .analog   (c_analog[i]),
            .pad_in   (c_in[i]),
            .pad_out  (c_out[i]),
            .pad_oe_n (c_oe_n[i]),
            .pu_en    (c_pu_en[i]),
            .rd_bit   (c_rd[i])
        );
    end

    // pad outputs
    assign pa_out                 = c_out[3:0];
    assign pa_oe_n                = c_oe_n[3:0];
    assign pa_pu_en               = c_pu_en[3:0];
    assign pa_analog_en           = analog_mode_select[3:0] & c_usable[3:0];
    assign irq_shared_pin_b_out   = c_out[4];
    assign irq_shared_pin_b_oe_n  = c_oe_n[4];
    assign irq_shared_pin_b_pu_en = c_pu_en[4];
    assign pc_out                 = c_out[6:5];
    assign pc_oe_n                = c_oe_n[6:5];
    assign pc_pu_en               = c_pu_en[6:5];

    // in output mode the latch loops back, so a level change reaches the interrupt
    assign irq_level_a = c_rd[1];
    assign irq_level_b = c_rd[4];

    // read data; port registers return pin or latch per bit
    always_comb begin
        next_rdata = rdata;
        if (bus.rd) begin
            case (bus.addr)
                `GP_ADDR_OUT_A:  next_rdata = {4'h0, c_rd[3:0]};
                `GP_ADDR_OUT_B:  next_rdata = {3'h0, reset_shared_input & ~rst_pin_is_reset,
                                               1'b0, c_rd[4], 2'h0};
                `GP_ADDR_OUT_C:  next_rdata = {4'h0, c_rd[6], 2'h0, c_rd[5]};
                `GP_ADDR_DIR_A:  next_rdata = dir_select_group_a | ~8'(`GP_MASK_A);
                `GP_ADDR_DIR_B:  next_rdata = dir_select_group_b | ~8'(`GP_MASK_DIR_B);
                `GP_ADDR_DIR_C:  next_rdata = dir_select_group_c;
                `GP_ADDR_PU_A:   next_rdata = pullup_select_group_a;
                `GP_ADDR_PU_B:   next_rdata = pullup_select_group_b;
                `GP_ADDR_PU_C:   next_rdata = pullup_select_group_c;
                `GP_ADDR_ANALOG: next_rdata = analog_mode_select;
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a write to a port register reaches the pad in output mode
    sequence s_byte_wr_out_a;
        bus.wr && bus.addr == `GP_ADDR_OUT_A;
    endsequence

    a_dir_reset: assert property (
        @(posedge clk) disable iff (1'b0) $past(rst) |->
            dir_select_group_a == 8'hff && dir_select_group_b == 8'hff &&
            dir_select_group_c == 8'hff)
        else $error("direction registers not all ones after reset");

    a_latch_reset: assert property (
        @(posedge clk) disable iff (1'b0) $past(rst) |->
            out_latch_group_a == 8'h00 && out_latch_group_b == 8'h00 &&
            out_latch_group_c == 8'h00)
        else $error("output latches not clear after reset");

    a_oe_follows_dir: assert property (
        (pa_oe_n[0] == 1'b0) |-> (dir_select_group_a[0] == 1'b0 && analog_mode_select[0] == 1'b0))
        else $error("pin driven while direction says input");

    a_pullup_off_out: assert property (
        (c_oe_n != 7'h7f) |-> ((c_pu_en & ~c_oe_n) == 7'h00))
        else $error("pull-up connected on a driving pin");

    a_write_to_pad: assert property (
        s_byte_wr_out_a ##1 (dir_select_group_a[0] == 1'b0 && analog_mode_select[0] == 1'b0)
            |-> pa_out[0] == $past(bus.wdata[0]) && pa_oe_n[0] == 1'b0)
        else $error("written latch value not driven to pad");

    a_read_input: assert property (
        (bus.rd && bus.addr == `GP_ADDR_OUT_C && dir_select_group_c[0])
            |=> rdata[0] == $past(pc_in[0]))
        else $error("input-mode read did not return pin level");

    a_xtal_owns_pins: assert property (
        (osc_sel == GP_OSC_XTAL) |-> pa_oe_n[3:2] == 2'b11 && pa_pu_en[3:2] == 2'b00 &&
            pa_analog_en[3:2] == 2'b00)
        else $error("oscillator pin used as port under crystal");

    a_reset_ignored: assert property (
        (option_loaded && !rst_pin_is_reset) |-> !ext_reset_req)
        else $error("port-mode pin still requests reset");

    a_hold_before_load: assert property (
        (!option_loaded && !reset_shared_input) |-> ext_reset_req ##1 !option_loaded)
        else $error("low pin did not hold reset before option read");

    a_analog_quiet: assert property (
        analog_mode_select[1] |-> pa_oe_n[1] && !pa_pu_en[1] && !irq_level_a)
        else $error("analog pin kept digital function");

    a_ext_clk_pins: assert property (
        (osc_sel == GP_OSC_EXT) |-> pa_oe_n[3] && !pa_pu_en[3] && !pa_analog_en[3])
        else $error("clock input pin used as port under external clock");

    // only the crystal takes the output-side pin away from the port
    a_int_osc_free: assert property (
        (osc_sel != GP_OSC_XTAL && !dir_select_group_a[2] && !analog_mode_select[2])
            |-> !pa_oe_n[2] && pa_out[2] == out_latch_group_a[2])
        else $error("shared output-side pin not driven as port");

    a_pullup_input: assert property (
        (dir_select_group_a[0] && pullup_select_group_a[0] && !analog_mode_select[0])
            |-> pa_pu_en[0])
        else $error("selected pull-up missing on input pin");

    // a single-bit write touches only the addressed direction bit
    sequence s_bit_wr_dir_a1;
        bus.bit_wr && !bus.wr && bus.addr == `GP_ADDR_DIR_A && bus.bit_idx == 3'h1;
    endsequence

    a_bit_write: assert property (
        s_bit_wr_dir_a1 |=> dir_select_group_a[1] == $past(bus.bit_val) &&
            dir_select_group_a[0] == $past(dir_select_group_a[0]))
        else $error("single-bit write did not land on its bit alone");

    a_group_c_drive: assert property (
        !dir_select_group_c[3] |-> !pc_oe_n[1] && pc_out[1] == out_latch_group_c[3])
        else $error("group c high bit not driven in output mode");

endmodule

// ---- gp_pad_model.sv ----
`timescale 1ns/1ps

// outside devices on the seven io pins; they back off while the port drives
module gp_pad_model (
    // clock for the floating pattern
    input  wire logic       clk,
    // pin controls from the port
    input  wire logic [6:0] oe_n,
    input  wire logic [6:0] drv,
    input  wire logic [6:0] pu_en,
    // outside device drive
    input  wire logic [6:0] ext_en,
    input  wire logic [6:0] ext_val,
    // resolved pin levels
    output logic      [6:0] pad
);
    logic [6:0] flt;

    // an undriven pin without pull-up wanders, so nothing may rely on it
    initial flt = 7'h00;
    always @(posedge clk) begin
        flt <= ~flt;
    end

    // port drive first, then the outside device, then the pull-up
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (!oe_n[i]) pad[i] = drv[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (pu_en[i]) pad[i] = 1'b1;
            else pad[i] = flt[i];
        end
    end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "gp_defines.svh"

// compare, count, and report a mismatch at once
`define CHK(name_s, exp_v, got_v) begin cmp_count++; if ((got_v) !== (exp_v)) begin n_fail++; \
    $display("BAD %s expected %h seen %h", name_s, exp_v, got_v); end end

module tb_top
    import gp_pkg::*;
;
    logic        clk, rst, option_loaded, ext_reset_req, osc_in_is_clock, osc_out_is_clock;
    logic        pb_in, pb_out, pb_oe_n, pb_pu_en, rst_pin, irq_a, irq_b;
    gp_bus_s     bus;
    logic [7:0]  rdata, option_byte, v;
    logic [3:0]  pa_in, pa_out, pa_oe_n, pa_pu_en, pa_analog_en;
    logic [1:0]  pc_in, pc_out, pc_oe_n, pc_pu_en;
    logic [6:0]  ext_en, ext_val, pad;
    logic [15:0] a, amap [10];
    int          n_fail, cmp_count, seed, osc, pmode, idx, rg[int];
    logic [7:0]  rq[$];

    gp_ports #(.DATA_W(8)) uut (
        .clk, .rst, .bus, .rdata, .option_byte, .option_loaded, .ext_reset_req,
        .osc_in_is_clock, .osc_out_is_clock, .pa_in, .pa_out, .pa_oe_n, .pa_pu_en,
        .pa_analog_en, .irq_shared_pin_b_in(pb_in), .irq_shared_pin_b_out(pb_out),
        .irq_shared_pin_b_oe_n(pb_oe_n), .irq_shared_pin_b_pu_en(pb_pu_en),
        .reset_shared_input(rst_pin), .pc_in, .pc_out, .pc_oe_n, .pc_pu_en,
        .irq_level_a(irq_a), .irq_level_b(irq_b)
    );
    gp_pad_model pads (
        .clk, .oe_n({pc_oe_n, pb_oe_n, pa_oe_n}), .drv({pc_out, pb_out, pa_out}),
        .pu_en({pc_pu_en, pb_pu_en, pa_pu_en}), .ext_en, .ext_val, .pad
    );
    assign {pc_in, pb_in, pa_in} = pad;

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // stored value as the port keeps it; -1 marks an unmapped address
    function automatic int fix(int ad, int d);
        case (ad)
            `GP_ADDR_DIR_A: return (d & 8'h0f) | 8'hf0;
            `GP_ADDR_DIR_B: return (d & 8'h04) | 8'hfb;
            `GP_ADDR_DIR_C: return d & 8'hff;
            `GP_ADDR_OUT_A, `GP_ADDR_PU_A, `GP_ADDR_ANALOG: return d & 8'h0f;
            `GP_ADDR_OUT_B, `GP_ADDR_PU_B: return d & 8'h04;
            `GP_ADDR_OUT_C, `GP_ADDR_PU_C: return d & 8'h09;
            default: return -1;
        endcase
    endfunction
    // seven io pins of a register family, group a address given
    function automatic logic [6:0] pk(int ad);
        int va, vb, vc;
        va = rg[ad];
        vb = rg[ad + 1];
        vc = rg[ad + 2];
        return {vc[3], vc[0], vb[2], va[3:0]};
    endfunction
    // group a pins left to the port by the clock source
    function automatic logic [3:0] oscm();
        return (osc == 1) ? 4'h3 : (osc == 2) ? 4'h7 : 4'hf;
    endfunction
    function automatic logic [6:0] usable();
        return {3'h7, oscm() & ~4'(rg[`GP_ADDR_ANALOG])};
    endfunction
    // read-back per pin: pin level in input mode, latch in output mode
    function automatic logic [6:0] rb();
        logic [6:0] d, lv;
        d = pk(`GP_ADDR_DIR_A);
        lv = (ext_en & ext_val) | (~ext_en & pk(`GP_ADDR_PU_A));
        return usable() & ((d & lv) | (~d & pk(`GP_ADDR_OUT_A)));
    endfunction
    function automatic logic [7:0] exp_rd(logic [15:0] ad);
        logic [6:0] r;
        r = rb();
        case (ad)
            `GP_ADDR_OUT_A: return {4'h0, r[3:0]};
            `GP_ADDR_OUT_B: return {3'h0, rst_pin & 1'(pmode), 1'b0, r[4], 2'h0};
            `GP_ADDR_OUT_C: return {4'h0, r[6], 2'h0, r[5]};
            default: return rg.exists(ad) ? 8'(rg[ad]) : 8'h00;
        endcase
    endfunction

    // pad controls against the model
    task automatic chk_pads();
        logic [6:0] u, d, r;
        u = usable();
        d = pk(`GP_ADDR_DIR_A);
        r = rb();
        `CHK("oe_n", ~(u & ~d), {pc_oe_n, pb_oe_n, pa_oe_n})
        `CHK("pu_en", u & d & pk(`GP_ADDR_PU_A), {pc_pu_en, pb_pu_en, pa_pu_en})
        `CHK("out", u & ~d & pk(`GP_ADDR_OUT_A), u & ~d & {pc_out, pb_out, pa_out})
        `CHK("irq", {r[4], r[1]}, {irq_b, irq_a})
        `CHK("analog", oscm() & 4'(rg[`GP_ADDR_ANALOG]), pa_analog_en)
    endtask

    // one bus cycle: set after a falling edge, taken at the rising edge
    task automatic bus_op(logic [15:0] ad, logic [7:0] d, logic [2:0] kind, logic [2:0] i);
        @(negedge clk);
        bus.addr = ad;
        bus.wdata = d;
        {bus.wr, bus.rd, bus.bit_wr} = kind;
        bus.bit_idx = i;
        bus.bit_val = d[0];
        @(negedge clk);
        bus = '0;
    endtask
    task automatic wr(logic [15:0] ad, logic [7:0] d);
        int t;
        bus_op(ad, d, 3'b100, 3'h0);
        t = fix(ad, d);
        if (t >= 0) rg[ad] = t;
    endtask
    // single-bit write changes the stored bit only
    task automatic bw(logic [15:0] ad, logic [2:0] i, logic b);
        bus_op(ad, {7'h00, b}, 3'b001, i);
        if (rg.exists(ad)) rg[ad] = fix(ad, b ? rg[ad] | (1 << i) : rg[ad] & ~(1 << i));
    endtask
    task automatic rd(logic [15:0] ad);
        logic [7:0] e;
        rq.push_back(exp_rd(ad));
        bus_op(ad, 8'h00, 3'b010, 3'h0);
        e = rq.pop_front();
        `CHK("rdata", e, rdata)
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // reset with an option byte; low keeps the shared pin low after release
    task automatic do_reset(logic [7:0] ob, int low);
        int k;
        @(negedge clk);
        rst = 1'b1;
        option_byte = ob;
        rst_pin = (low == 0);
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rg.delete();
        foreach (amap[j]) rg[amap[j]] = fix(amap[j], (amap[j][15:4] == 12'hff2) ? 8'hff : 8'h00);
        osc = (ob[1:0] == 2'b11) ? 0 : ob[1:0];
        pmode = !ob[2];
        repeat (low) begin
            @(negedge clk);
            `CHK("held", 2'b10, {ext_reset_req, option_loaded})
        end
        rst_pin = 1'b1;
        for (k = 0; k < 8 && option_loaded !== 1'b1; k++) @(negedge clk);
        if (k == 8) begin
            n_fail++;
            final_report();
        end
    endtask

    initial begin
        seed = 51941;
        rst = 1'b1;
        bus = '0;
        option_byte = 8'h04;
        rst_pin = 1'b1;
        ext_en = '1;
        ext_val = 7'h00;
        amap = '{`GP_ADDR_OUT_A, `GP_ADDR_OUT_B, `GP_ADDR_OUT_C, `GP_ADDR_DIR_A,
                 `GP_ADDR_DIR_B, `GP_ADDR_DIR_C, `GP_ADDR_PU_A, `GP_ADDR_PU_B,
                 `GP_ADDR_PU_C, `GP_ADDR_ANALOG};
        // reset-pin mode with the pin held low at first
        do_reset(8'h04, 4);
        foreach (amap[j]) rd(amap[j]);
        rd(16'hff05);
        chk_pads();
        rst_pin = 1'b0;
        #1;
        `CHK("reset in", 1'b1, ext_reset_req)
        rst_pin = 1'b1;
        wr(`GP_ADDR_DIR_C, 8'h09);
        // random byte and bit traffic, unmapped address included
        repeat (150) begin
            idx = {$random(seed)} % 11;
            v = 8'($random(seed));
            ext_val = 7'($random(seed));
            a = (idx == 10) ? 16'hff05 : amap[idx];
            if (a == `GP_ADDR_DIR_C) v = v & 8'h09;
            case ({$random(seed)} % 3)
                0: wr(a, v);
                1: bw(a, (a == `GP_ADDR_DIR_C) ? {1'b0, v[3], v[3]} : v[3:1], v[0]);
                default: rd(a);
            endcase
            chk_pads();
        end
        // released pins rise only through the pull-ups
        wr(`GP_ADDR_ANALOG, 8'h00);
        wr(`GP_ADDR_DIR_A, 8'hff);
        wr(`GP_ADDR_DIR_B, 8'hff);
        wr(`GP_ADDR_DIR_C, 8'h09);
        wr(`GP_ADDR_PU_A, 8'h0f);
        wr(`GP_ADDR_PU_B, 8'h04);
        wr(`GP_ADDR_PU_C, 8'h09);
        ext_en = 7'h00;
        rd(`GP_ADDR_OUT_A);
        rd(`GP_ADDR_OUT_C);
        chk_pads();
        ext_en = '1;
        // every clock source, shared pin as a port input
        for (int o = 0; o < 4; o++) begin
            do_reset({6'h00, 2'(o)}, 0);
            `CHK("osc in", 1'(o == 1 || o == 2), osc_in_is_clock)
            `CHK("osc out", 1'(o == 1), osc_out_is_clock)
            wr(`GP_ADDR_DIR_A, 8'h00);
            wr(`GP_ADDR_OUT_A, 8'h0a);
            chk_pads();
            rd(`GP_ADDR_OUT_A);
            wr(`GP_ADDR_DIR_A, 8'hff);
            wr(`GP_ADDR_ANALOG, 8'h05);
            chk_pads();
            rd(`GP_ADDR_OUT_A);
            rst_pin = 1'(o % 2);
            rd(`GP_ADDR_OUT_B);
            `CHK("no reset", 1'b0, ext_reset_req)
            rst_pin = 1'b1;
        end
        final_report();
    end
endmodule
